// ---- hdl/timer_defs.svh ----
// offsets, field positions, reset values and command codes of the combined timer
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// apb byte offsets
`define REG_COUNT      8'h00
`define REG_COMMAND    8'h04
`define REG_STATUS     8'h08
`define REG_CONFIG     8'h0C
`define REG_ADDRESS    8'h10
`define REG_VECTOR     8'h14

// status register fields
`define ST_OVERFLOW    0
`define ST_RUN         1
`define ST_IRQ         2
`define ST_IRQ_ENABLE  3

// config register fields
`define CF_MODE        0
`define CF_SRC_LO      4
`define CF_SRC_HI      5
`define CF_SB_LO       8
`define CF_SB_HI       11

// address strap register fields
`define AD_DEST_LO     0
`define AD_DEST_HI     5
`define AD_SRC_LO      8
`define AD_SRC_HI      13

// function output control codes
`define CMD_CLEAR_START 4'h9
`define CMD_STOP        4'h0

// reset values and the vector ones limit
`define RST_COUNT      16'h0000
`define RST_ADDR       6'h30
`define RST_VECTOR     16'h0025
`define RST_SB_SEL     4'hF
`define MAX_VEC_ONES   4

// allowed oscillator range in hz
`define OSC_MIN_HZ     25000
`define OSC_MAX_HZ     10000000

`endif

// ---- hdl/timer_pkg.sv ----
// types shared by the combined timer design
package timer_pkg;

  typedef enum logic [0:0] {
    MODE_INTERVAL = 1'b0,
    MODE_WATCHDOG = 1'b1
  } timer_mode_t;

  typedef enum logic [1:0] {
    SRC_OSC     = 2'b00,
    SRC_LINE    = 2'b01,
    SRC_PROCESS = 2'b10,
    SRC_NONE    = 2'b11
  } tick_src_t;

  typedef enum logic [1:0] {
    IRQ_IDLE    = 2'b00,
    IRQ_PENDING = 2'b01,
    IRQ_VECTOR  = 2'b10
  } irq_state_t;

endpackage : timer_pkg

// ---- hdl/tick_sync.sv ----
// two-flop synchronisers and rising edge detectors for the timing source pins
`timescale 1ns/10ps

module tick_sync #(
  parameter int N = 3
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [N-1:0] pin_in,
  output logic      [N-1:0] rise
);

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_ch
      logic meta;
      logic stable;
      logic last;
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          meta   <= 1'b0;
          stable <= 1'b0;
          last   <= 1'b0;
          rise[g] <= 1'b0;
        end
        else
        begin
          meta    <= pin_in[g];
          stable  <= meta;
          last    <= stable;
          rise[g] <= stable & ~last;
        end
      end
    end
  endgenerate

endmodule : tick_sync

// ---- hdl/combo_timer_device.sv ----
// combined interval and watchdog timer with apb registers and i/o bus side
`timescale 1ns/10ps
`include "timer_defs.svh"

module combo_timer_device (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [5:0]  dest_addr_bus,
  input  wire logic [5:0]  source_addr_bus,
  input  wire logic        function_output_cmd,
  input  wire logic [3:0]  fo_control_bits,
  input  wire logic        data_load_strobe,
  input  wire logic        data_read_strobe,
  input  wire logic        isr_load_strobe,
  input  wire logic [15:0] data_bus_lines_in,
  output logic      [15:0] data_bus_lines_out,
  output logic             data_bus_lines_oe,
  output logic      [15:0] status_bit_lines,
  input  wire logic        irq_sync_strobe,
  input  wire logic        irq_ack,
  input  wire logic        priority_chain_in,
  output logic             priority_chain_out,
  output logic             irq_request,
  input  wire logic        osc_pin,
  input  wire logic        line_pin,
  input  wire logic        process_pin,
  output logic             relay_drive,
  output logic             alarm_drive
);

  logic [15:0]           count;
  logic [15:0]           next_count;
  logic                  count_run_ff;
  logic                  overflow_ff;
  logic                  irq_enable;
  timer_pkg::irq_state_t irq_state;
  timer_pkg::timer_mode_t mode;
  timer_pkg::tick_src_t  src_sel;
  logic [3:0]            sb_sel;
  logic [5:0]            dest_strap;
  logic [5:0]            src_strap;
  logic [15:0]           vector;
  logic [2:0]            rise;
  logic                  tick;
  logic                  dest_hit;
  logic                  src_hit;
  logic                  fo_hit;
  logic                  cmd_clear_start;
  logic                  cmd_stop;
  logic                  apb_setup;
  logic                  apb_wr;
  logic                  load_io;
  logic                  load_apb;
  logic                  ov_fall;
  logic                  grant;
  logic [3:0]            wr_cmd;
  logic [2:0]            vec_ones;

  tick_sync #(
    .N (3)
  ) u_tick_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  ({process_pin, line_pin, osc_pin}),
    .rise    (rise)
  );

  // selected timing source
  always_comb
  begin
    case (src_sel)
      timer_pkg::SRC_OSC:     tick = rise[0];
      timer_pkg::SRC_LINE:    tick = rise[1];
      timer_pkg::SRC_PROCESS: tick = rise[2];
      default:                tick = 1'b0;
    endcase
  end

  // per-bit strapped address match
  assign dest_hit = &(~(dest_addr_bus ^ dest_strap));
  assign src_hit  = &(~(source_addr_bus ^ src_strap));

  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pready & pwrite;
  assign wr_cmd    = (apb_wr && paddr == `REG_COMMAND) ? pwdata[3:0] : 4'hF;
  assign fo_hit    = function_output_cmd & dest_hit;
  assign cmd_clear_start = (fo_hit && fo_control_bits == `CMD_CLEAR_START)
                           || wr_cmd == `CMD_CLEAR_START;
  assign cmd_stop  = (fo_hit && fo_control_bits == `CMD_STOP)
                     || wr_cmd == `CMD_STOP;
  assign load_io   = data_load_strobe & dest_hit;
  assign load_apb  = apb_wr && paddr == `REG_COUNT;
  assign grant     = irq_ack & priority_chain_in & (irq_state == timer_pkg::IRQ_PENDING);
  assign vec_ones  = 3'($countones(pwdata[15:0]) > `MAX_VEC_ONES);

  // counter: loads win over counting
  always_comb
  begin
    if (load_io)
      next_count = data_bus_lines_in;
    else if (load_apb)
      next_count = pwdata[15:0];
    else if (count_run_ff && tick)
      next_count = count + 16'h0001;
    else
      next_count = count;
  end

  assign ov_fall = count_run_ff & count[15] & ~next_count[15];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= `RST_COUNT;
    else
      count <= next_count;
  end

  // clock control flip-flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_run_ff <= 1'b0;
    else if (cmd_clear_start)
      count_run_ff <= 1'b1;
    else if (cmd_stop)
      count_run_ff <= 1'b0;
  end

  // overflow flag: a new overflow wins over a clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overflow_ff <= 1'b0;
    else if (ov_fall)
      overflow_ff <= 1'b1;
    else if (cmd_clear_start)
      overflow_ff <= 1'b0;
  end

  // interrupt enable from the status bit position of the data lines
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_enable <= 1'b0;
    else if (isr_load_strobe)
      irq_enable <= data_bus_lines_in[sb_sel];
  end

  // interrupt request state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_state <= timer_pkg::IRQ_IDLE;
    else
    begin
      case (irq_state)
        timer_pkg::IRQ_IDLE:
          if (irq_sync_strobe && overflow_ff && irq_enable && !cmd_clear_start
              && mode == timer_pkg::MODE_INTERVAL)
            irq_state <= timer_pkg::IRQ_PENDING;
        timer_pkg::IRQ_PENDING:
          if (grant)
            irq_state <= timer_pkg::IRQ_VECTOR;
          else if (cmd_clear_start)
            irq_state <= timer_pkg::IRQ_IDLE;
        timer_pkg::IRQ_VECTOR:
          if (!overflow_ff || cmd_clear_start)
            irq_state <= timer_pkg::IRQ_IDLE;
        default:
          irq_state <= timer_pkg::IRQ_IDLE;
      endcase
    end
  end

  // i/o bus outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_bus_lines_out <= 16'h0000;
      data_bus_lines_oe  <= 1'b0;
    end
    else if (grant)
    begin
      data_bus_lines_out <= vector;
      data_bus_lines_oe  <= 1'b1;
    end
    else if (data_read_strobe && src_hit)
    begin
      data_bus_lines_out <= count;
      data_bus_lines_oe  <= 1'b1;
    end
    else
    begin
      data_bus_lines_out <= 16'h0000;
      data_bus_lines_oe  <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_request        <= 1'b0;
      priority_chain_out <= 1'b0;
      status_bit_lines   <= 16'h0000;
    end
    else
    begin
      irq_request        <= (irq_state == timer_pkg::IRQ_PENDING) && !grant;
      priority_chain_out <= priority_chain_in && irq_state != timer_pkg::IRQ_PENDING;
      status_bit_lines   <= (irq_state == timer_pkg::IRQ_PENDING)
                            ? (16'h0001 << sb_sel) : 16'h0000;
    end
  end

  // watchdog outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      relay_drive <= 1'b0;
      alarm_drive <= 1'b0;
    end
    else
    begin
      relay_drive <= overflow_ff && mode == timer_pkg::MODE_WATCHDOG;
      alarm_drive <= overflow_ff && mode == timer_pkg::MODE_WATCHDOG;
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode       <= timer_pkg::MODE_INTERVAL;
      src_sel    <= timer_pkg::SRC_OSC;
      sb_sel     <= `RST_SB_SEL;
      dest_strap <= `RST_ADDR;
      src_strap  <= `RST_ADDR;
      vector     <= `RST_VECTOR;
    end
    else if (apb_wr)
    begin
      case (paddr)
        `REG_CONFIG:
        begin
          mode    <= timer_pkg::timer_mode_t'(pwdata[`CF_MODE]);
          src_sel <= timer_pkg::tick_src_t'(pwdata[`CF_SRC_HI:`CF_SRC_LO]);
          sb_sel  <= pwdata[`CF_SB_HI:`CF_SB_LO];
        end
        `REG_ADDRESS:
        begin
          dest_strap <= pwdata[`AD_DEST_HI:`AD_DEST_LO];
          src_strap  <= pwdata[`AD_SRC_HI:`AD_SRC_LO];
        end
        `REG_VECTOR:
          if (vec_ones == 3'h0)
            vector <= pwdata[15:0];
        default:
          vector <= vector;
      endcase
    end
  end

  // apb answer: one access cycle, data and error registered in setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (apb_setup)
    begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      case (paddr)
        `REG_COUNT:
          prdata <= {16'h0000, count};
        `REG_COMMAND:
          prdata <= 32'h0000_0000;
        `REG_STATUS:
        begin
          prdata[`ST_OVERFLOW]   <= overflow_ff;
          prdata[`ST_RUN]        <= count_run_ff;
          prdata[`ST_IRQ]        <= irq_state == timer_pkg::IRQ_PENDING;
          prdata[`ST_IRQ_ENABLE] <= irq_enable;
          pslverr                <= pwrite;
        end
        `REG_CONFIG:
        begin
          prdata[`CF_MODE]             <= mode;
          prdata[`CF_SRC_HI:`CF_SRC_LO] <= src_sel;
          prdata[`CF_SB_HI:`CF_SB_LO]   <= sb_sel;
        end
        `REG_ADDRESS:
        begin
          prdata[`AD_DEST_HI:`AD_DEST_LO] <= dest_strap;
          prdata[`AD_SRC_HI:`AD_SRC_LO]   <= src_strap;
        end
        `REG_VECTOR:
        begin
          prdata  <= {16'h0000, vector};
          pslverr <= pwrite && ($countones(pwdata[15:0]) > `MAX_VEC_ONES);
        end
        default:
          pslverr <= 1'b1;
      endcase
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  AST_OV_ON_FALL: assert property (@(posedge pclk) disable iff (!presetn)
    $past(count_run_ff) && $fell(count[15]) |-> overflow_ff)
    else $error("overflow not set on bit 15 fall");

  AST_OV_ONLY_RUNNING: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(overflow_ff) |-> $past(count_run_ff) && $past(count[15]) && !count[15])
    else $error("overflow set without running fall");

  AST_START: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_clear_start |=> count_run_ff && irq_state != timer_pkg::IRQ_PENDING)
    else $error("clear-start did not start timer");

  AST_STOP: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_stop && !cmd_clear_start |=> !count_run_ff
    ##1 ($stable(count) || $past(load_io || load_apb)))
    else $error("stop did not halt timer");

  AST_IRQ_SYNC: assert property (@(posedge pclk) disable iff (!presetn)
    irq_state == timer_pkg::IRQ_IDLE && irq_sync_strobe && overflow_ff && irq_enable
    && mode == timer_pkg::MODE_INTERVAL && !cmd_clear_start |=> ##1 irq_request || grant
    || $past(grant))
    else $error("interrupt request not raised at sync strobe");

  AST_WATCHDOG: assert property (@(posedge pclk) disable iff (!presetn)
    overflow_ff && mode == timer_pkg::MODE_WATCHDOG |=> relay_drive && alarm_drive)
    else $error("watchdog outputs not driven");

  AST_COUNT_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    !load_io && !load_apb |=> count == $past(count) + 16'($past(count_run_ff && tick)))
    else $error("counter step wrong");

  AST_CHAIN: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |->
    priority_chain_out == $past(priority_chain_in && irq_state != timer_pkg::IRQ_PENDING))
    else $error("priority chain pass wrong");

  AST_VECTOR: assert property (@(posedge pclk) disable iff (!presetn)
    grant |=> data_bus_lines_oe && data_bus_lines_out == $past(vector)
    && $countones(data_bus_lines_out) <= 4)
    else $error("vector not driven correctly");

  AST_SB_POS: assert property (@(posedge pclk) disable iff (!presetn)
    irq_request |-> status_bit_lines == (16'h0001 << $past(sb_sel)))
    else $error("status bit position wrong");

endmodule : combo_timer_device

// ---- testbench/io_host.sv ----
// processor side of the i/o bus: addresses, strobes and data lines
`timescale 1ns/10ps

module io_host (
  input  wire logic  pclk,
  output logic [5:0] dest_addr_bus,
  output logic [5:0] source_addr_bus,
  output logic       function_output_cmd,
  output logic [3:0] fo_control_bits,
  output logic       data_load_strobe,
  output logic       data_read_strobe,
  output logic       isr_load_strobe,
  output logic       irq_sync_strobe,
  output logic       irq_ack,
  output logic [15:0] host_data
);
  initial
  begin
    {dest_addr_bus, source_addr_bus, fo_control_bits} = '0;
    {function_output_cmd, data_load_strobe, data_read_strobe} = '0;
    {isr_load_strobe, irq_sync_strobe, irq_ack} = '0;
    host_data = 16'h5A5A;
  end

  // kind: 0 load, 1 function command, 2 isr load, 3 sync, 4 ack, 5 read
  task xfer(input logic [2:0] kind, input logic [5:0] a, input logic [15:0] v);
    @(posedge pclk);
    dest_addr_bus <= a;
    source_addr_bus <= a;
    host_data <= v;
    fo_control_bits <= v[3:0];
    data_load_strobe <= (kind == 3'd0);
    function_output_cmd <= (kind == 3'd1);
    isr_load_strobe <= (kind == 3'd2);
    irq_sync_strobe <= (kind == 3'd3);
    irq_ack <= (kind == 3'd4);
    data_read_strobe <= (kind == 3'd5);
    @(posedge pclk);
    {function_output_cmd, data_load_strobe, data_read_strobe} <= '0;
    {isr_load_strobe, irq_sync_strobe, irq_ack} <= '0;
    // released lines show a changing pattern, not the last value
    host_data <= ~v;
  endtask : xfer
endmodule : io_host

// ---- testbench/test_interval_watchdog_timer.sv ----
// self-checking bench of the combined interval and watchdog timer
`timescale 1ns/10ps
`include "timer_defs.svh"

module test_interval_watchdog_timer;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic        rerr, function_output_cmd, data_load_strobe, data_read_strobe;
  logic        isr_load_strobe, irq_sync_strobe, irq_ack, data_bus_lines_oe;
  logic        priority_chain_in, priority_chain_out, irq_request;
  logic        relay_drive, alarm_drive;
  logic [5:0]  dest_addr_bus, source_addr_bus;
  logic [3:0]  fo_control_bits;
  logic [15:0] host_data, data_bus_lines_in, data_bus_lines_out, status_bit_lines;
  logic [2:0]  pins;
  int          n_mismatch, n_tests, i;

  assign data_bus_lines_in = data_bus_lines_oe ? data_bus_lines_out : host_data;

  io_host host (.pclk, .dest_addr_bus, .source_addr_bus, .function_output_cmd,
    .fo_control_bits, .data_load_strobe, .data_read_strobe, .isr_load_strobe,
    .irq_sync_strobe, .irq_ack, .host_data);

  combo_timer_device dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .dest_addr_bus, .source_addr_bus,
    .function_output_cmd, .fo_control_bits, .data_load_strobe, .data_read_strobe,
    .isr_load_strobe, .data_bus_lines_in, .data_bus_lines_out, .data_bus_lines_oe,
    .status_bit_lines, .irq_sync_strobe, .irq_ack, .priority_chain_in,
    .priority_chain_out, .irq_request, .osc_pin(pins[0]), .line_pin(pins[1]),
    .process_pin(pins[2]), .relay_drive, .alarm_drive);

  always #20 pclk = ~pclk;

  task wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
    begin
      n_mismatch++;
      wrap_up;
    end
    rdata = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdata, exp, "register read");
  endtask : rd

  task pulse(input int p, input int n);
    repeat (n)
    begin
      @(posedge pclk);
      pins[p] <= 1'b1;
      repeat (3) @(posedge pclk);
      pins[p] <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    repeat (6) @(posedge pclk);
  endtask : pulse

  initial
  begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, pins} = '0;
    {n_mismatch, n_tests} = '0;
    priority_chain_in = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`REG_STATUS, 32'h0000_0000);
    rd(`REG_CONFIG, 32'h0000_0F00);
    rd(`REG_ADDRESS, 32'h0000_3030);
    rd(`REG_VECTOR, 32'h0000_0025);
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk(rerr, 1, "unmapped refused");
    chk(priority_chain_out, 1, "grant passed");
    $display("test reset done");
    // bit 15 falls by a load while stopped: no overflow
    host.xfer(0, 6'h30, 16'hFFFF);
    host.xfer(0, 6'h30, 16'h0000);
    rd(`REG_STATUS, 32'h0000_0000);
    host.xfer(0, 6'h31, 16'h1234);
    rd(`REG_COUNT, 32'h0000_0000);
    apb(1'b1, `REG_ADDRESS, 32'h0000_2525);
    host.xfer(0, 6'h25, 16'h0007);
    rd(`REG_COUNT, 32'h0000_0007);
    host.xfer(5, 6'h25, 16'h0000);
    @(negedge pclk);
    chk({data_bus_lines_oe, data_bus_lines_out}, 32'h0001_0007, "read");
    apb(1'b1, `REG_ADDRESS, 32'h0000_3030);
    $display("test address done");
    for (int s = 0; s < 3; s++)
    begin
      apb(1'b1, `REG_CONFIG, 32'h0000_0F00 | (s << 4));
      host.xfer(0, 6'h30, 16'h0000);
      host.xfer(1, 6'h30, 16'h0009);
      pulse(s, 2);
      pulse((s + 1) % 3, 1);
      host.xfer(1, 6'h30, 16'h0000);
      pulse(s, 1);
      rd(`REG_COUNT, 32'h0000_0002);
    end
    $display("test sources done");
    apb(1'b1, `REG_CONFIG, 32'h0000_0F00);
    host.xfer(2, 6'h30, 16'h8000);
    host.xfer(0, 6'h30, 16'hFFFD);
    host.xfer(1, 6'h30, 16'h0009);
    pulse(0, 2);
    rd(`REG_STATUS, 32'h0000_000A);
    pulse(0, 1);
    rd(`REG_STATUS, 32'h0000_000B);
    rd(`REG_COUNT, 32'h0000_0000);
    host.xfer(3, 6'h30, 16'h0000);
    for (i = 0; i < 20 && irq_request !== 1'b1; i++)
      @(posedge pclk);
    if (i == 20)
    begin
      n_mismatch++;
      wrap_up;
    end
    @(negedge pclk);
    chk(irq_request, 1, "request");
    chk(status_bit_lines, 16'h8000, "status line");
    chk(priority_chain_out, 0, "grant held");
    // upstream holds the grant: the acknowledge must not reach this timer
    @(posedge pclk);
    priority_chain_in <= 1'b0;
    host.xfer(4, 6'h30, 16'h0000);
    @(negedge pclk);
    chk({data_bus_lines_oe, irq_request}, 1, "no grant from upstream");
    @(posedge pclk);
    priority_chain_in <= 1'b1;
    host.xfer(4, 6'h30, 16'h0000);
    @(negedge pclk);
    chk({data_bus_lines_oe, data_bus_lines_out}, 32'h0001_0025, "vector");
    chk({irq_request, relay_drive}, 0, "after ack");
    apb(1'b1, `REG_VECTOR, 32'h0000_001F);
    chk(rerr, 1, "vector refused");
    rd(`REG_VECTOR, 32'h0000_0025);
    host.xfer(1, 6'h30, 16'h0009);
    rd(`REG_STATUS, 32'h0000_000A);
    host.xfer(1, 6'h30, 16'h0000);
    rd(`REG_STATUS, 32'h0000_0008);
    apb(1'b1, `REG_COMMAND, 32'h0000_0009);
    rd(`REG_STATUS, 32'h0000_000A);
    apb(1'b1, `REG_STATUS, 32'h0000_0000);
    chk(rerr, 1, "status write refused");
    apb(1'b1, `REG_COMMAND, 32'h0000_0000);
    rd(`REG_STATUS, 32'h0000_0008);
    $display("test interval done");
    apb(1'b1, `REG_CONFIG, 32'h0000_0F01);
    host.xfer(0, 6'h30, 16'hFFFE);
    host.xfer(1, 6'h30, 16'h0009);
    pulse(0, 1);
    host.xfer(0, 6'h30, 16'hFFFE);
    pulse(0, 1);
    chk({relay_drive, alarm_drive}, 0, "reloaded");
    pulse(0, 1);
    host.xfer(3, 6'h30, 16'h0000);
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    chk({relay_drive, alarm_drive, irq_request}, 3'b110, "watchdog");
    $display("test watchdog done");
    wrap_up;
  end
endmodule : test_interval_watchdog_timer
